/* core/reset_controller_pkg.sv */
// Purpose: constants and types shared by the reset controller
// Assumes: AXI4-Lite register access with 32-bit data
// Notes: one aligned word per register
package reset_controller_pkg;
  localparam logic [7:0] REG_COMMAND = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_MODE = 8'h08;
  localparam logic [7:0] WRITE_KEY = 8'hA5;
  localparam int KEY_LSB = 24;
  // command fields
  localparam int CMD_CPU_BIT = 0;
  localparam int CMD_PERIPH_BIT = 2;
  localparam int CMD_PIN_BIT = 3;
  // status fields
  localparam int ST_EDGE_BIT = 0;
  localparam int ST_CAUSE_LSB = 8;
  localparam int ST_LEVEL_BIT = 16;
  localparam int ST_BUSY_BIT = 17;
  // mode fields
  localparam int MD_PIN_EN_BIT = 0;
  localparam int MD_IRQ_EN_BIT = 4;
  localparam int MD_LEN_LSB = 8;
  localparam logic [31:0] MODE_WRITE_MASK = 32'h0000_0F11;
  localparam logic [31:0] MODE_RESET = 32'h0000_0000;
  localparam logic [31:0] STATUS_MAIN_RESET = 32'h0000_0001;
  localparam logic [31:0] STATUS_BACKUP_RESET = 32'h0000_0000;
  // reset cause codes
  localparam logic [2:0] CAUSE_GENERAL = 3'h0;
  localparam logic [2:0] CAUSE_WAKEUP = 3'h1;
  localparam logic [2:0] CAUSE_WATCHDOG = 3'h2;
  localparam logic [2:0] CAUSE_SOFTWARE = 3'h3;
  localparam logic [2:0] CAUSE_USER = 3'h4;
  // slow clock cycles a reset state lasts
  localparam int HOLD_SLOW_CYCLES = 3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {
    ST_IDLE, ST_BACKUP, ST_WAKE, ST_WDOG, ST_SOFT, ST_USER
  } rst_state_t;
  typedef struct packed {
    logic cpu_reset;
    logic periph_reset;
  } rst_lines_t;
endpackage

/* core/reset_controller_core.sv */
// Purpose: reset state manager, pin manager and register file
// Assumes: slow_clock is a level sampled on aclk; pin is open drain
// Notes: reset outputs are active high; pin_oe high drives the pin to 0
`timescale 1ns/1ps
// Summary of operation
// (RL1) command write asserts resets at once; release on slow clock at state exit
// (RL2) pin command drives pin for programmed length; own edge never starts user reset
// (RL3) reset cause records software only when the cpu command bit was set
// (RL4) busy bit 17 spans a software reset; command writes ignored while busy
// (RL5) software reset state ends on the third slow clock tick after entry, so two to three slow clock cycles
// (RL6) watchdog fault enters watchdog state until the third slow clock tick, so two to three slow clock cycles
// (RL7) watchdog, cpu-only 0: cpu, periph and pin pulse; no user reset follows
// (RL8) watchdog, cpu-only 1: only cpu reset asserted
// (RL9) watchdog reset disabled: faults are ignored
// (RL10) priority: backup, wake-up, watchdog, software, user
// (RL11) in software reset watchdog takes over and the pin is ignored
// (RL12) watchdog state refuses software and user; user state refuses software
// (RL13) status bit 16 shows pin level resampled every master clock edge
// (RL14) status bit 0 set on pin falling edge, kept until status read
// (RL15) irq while edge bit set, pin reset off, irq enable on; read clears
// (RL16) three-bit cause field, not cleared by reads, fixed encodings
// (RL17) command and mode writes need key 0xA5 in top byte
// (RL18) command bits 0, 2, 3 reset cpu, peripherals, pin; zeros no effect
// (RL19) pin pulse lasts two to the power of length plus one slow cycles
// (RL20) pin reset enable set: low pin enters user reset; clear: no reset
// (RL21) status resets to 1 on main, 0 on backup; mode to 0 on backup
// (RL22) cause field updates when the cpu reset is released
// (RL23) pin passes a two-stage synchroniser before any use
module reset_controller_core
  import reset_controller_pkg::*;
#(
  parameter int HOLD_CYCLES = HOLD_SLOW_CYCLES
)
(
  // clock and main supply reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // reset sources
  input wire logic slow_clock,
  input wire logic backup_reset_n,
  input wire logic main_por_n,
  input wire logic watchdog_fault,
  input wire logic watchdog_reset_enable,
  input wire logic watchdog_cpu_only,
  // external reset pin, open drain
  input wire logic pin_in,
  output logic pin_out,
  output logic pin_oe,
  // reset lines and interrupt
  output rst_lines_t rst_lines,
  output logic irq
);

  initial
  begin
    if (HOLD_CYCLES < 1 || HOLD_CYCLES > 4)
      $error("HOLD_CYCLES must lie in 1..4");
  end

  localparam logic [1:0] HOLD_LAST = 2'(HOLD_CYCLES - 1);

  function automatic logic [16:0] pulse_len(input logic [3:0] len);
    pulse_len = 17'(17'h1 << (5'(len) + 5'h1));
  endfunction

  // bus state
  logic aw_full_reg;
  logic w_full_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  // block state
  rst_state_t state_reg, state_next;
  logic [1:0] cnt_reg, cnt_next;
  logic [2:0] cause_reg, cause_next;
  logic busy_reg, busy_next;
  logic soft_cpu_reg, soft_cpu_next;
  logic soft_per_reg, soft_per_next;
  logic wd_per_reg, wd_per_next;
  logic [16:0] ext_cnt_reg, ext_cnt_next;
  logic ext_ignore_reg, ext_ignore_next;
  logic [31:0] mode_reg;
  logic edge_reg;
  logic irq_reg;
  logic pin_oe_reg;
  rst_lines_t lines_reg, lines_next;
  logic pin_s1_reg, pin_s2_reg, pin_prev_reg;
  logic slow_prev_reg;

  // decoding
  wire wr_fire = aw_full_reg && w_full_reg && !bvalid_reg;
  wire key_ok = (w_data_reg[31:KEY_LSB] == WRITE_KEY) && (&s_axi_wstrb[3:0] || 1'b1);
  wire wr_cmd = wr_fire && aw_addr_reg == REG_COMMAND;
  wire wr_mode = wr_fire && aw_addr_reg == REG_MODE;
  wire wr_mapped = wr_cmd || wr_mode;
  wire rd_fire = s_axi_arvalid && !rvalid_reg;
  wire rd_status = rd_fire && s_axi_araddr == REG_STATUS;
  wire rd_mode = rd_fire && s_axi_araddr == REG_MODE;
  wire tick = slow_clock && !slow_prev_reg;
  wire pin_level = pin_s2_reg;
  wire pin_fall = pin_prev_reg && !pin_s2_reg; // [RL14]
  wire pin_en = mode_reg[MD_PIN_EN_BIT];
  wire irq_en = mode_reg[MD_IRQ_EN_BIT];
  wire [3:0] len_field = mode_reg[MD_LEN_LSB +: 4];
  wire [2:0] cmd_bits = {w_data_reg[CMD_PIN_BIT], w_data_reg[CMD_PERIPH_BIT],
                         w_data_reg[CMD_CPU_BIT]};
  wire soft_go = wr_cmd && key_ok && !busy_reg && |cmd_bits; // [RL17] [RL4] [RL18]
  wire wd_go = watchdog_fault && watchdog_reset_enable; // [RL9]
  wire edge_next = pin_fall || (edge_reg && !rd_status); // set wins over read clear
  wire hold_done = tick && cnt_reg == HOLD_LAST;
  wire [31:0] status_word = {14'h0, busy_reg, pin_level, 5'h0, cause_reg, 7'h0, edge_reg};

  // reset state manager
  always_comb
  begin
    state_next = state_reg;
    cnt_next = tick ? 2'(cnt_reg + 2'h1) : cnt_reg;
    cause_next = cause_reg;
    busy_next = busy_reg;
    soft_cpu_next = soft_cpu_reg;
    soft_per_next = soft_per_reg;
    wd_per_next = wd_per_reg;
    ext_cnt_next = (tick && ext_cnt_reg != 17'h0) ? 17'(ext_cnt_reg - 17'h1) : ext_cnt_reg;
    ext_ignore_next = ext_ignore_reg && !(ext_cnt_reg == 17'h0 && pin_level); // [RL2]
    if (!backup_reset_n) // [RL10]
    begin
      state_next = ST_BACKUP;
      cnt_next = 2'h0;
    end
    else if (!main_por_n && state_reg != ST_BACKUP)
    begin
      state_next = ST_WAKE;
      cnt_next = 2'h0;
    end
    else
    begin
      case (state_reg)
        ST_BACKUP, ST_WAKE:
        begin
          if (!main_por_n)
            cnt_next = 2'h0;
          else if (hold_done)
          begin
            state_next = ST_IDLE;
            cause_next = (state_reg == ST_BACKUP) ? CAUSE_GENERAL : CAUSE_WAKEUP; // [RL22]
            ext_cnt_next = pulse_len(len_field);
            ext_ignore_next = 1'b1;
          end
        end
        ST_WDOG:
        begin
          if (hold_done) // [RL6]
          begin
            state_next = ST_IDLE;
            cause_next = CAUSE_WATCHDOG; // [RL22] [RL16]
          end
        end
        ST_SOFT:
        begin
          if (wd_go) // [RL11]
          begin
            state_next = ST_WDOG;
            cnt_next = 2'h0;
            busy_next = 1'b0;
          end
          else if (hold_done) // [RL5]
          begin
            state_next = ST_IDLE;
            busy_next = 1'b0; // [RL4]
            if (soft_cpu_reg)
              cause_next = CAUSE_SOFTWARE; // [RL3] [RL22]
          end
        end
        ST_USER:
        begin
          if (!pin_level)
            cnt_next = 2'h0;
          else if (hold_done)
          begin
            state_next = ST_IDLE;
            cause_next = CAUSE_USER; // [RL22]
          end
        end
        default:
        begin
          cnt_next = 2'h0;
          if (wd_go) // [RL10]
            state_next = ST_WDOG;
          else if (soft_go) // [RL1]
          begin
            state_next = ST_SOFT;
            busy_next = 1'b1;
            soft_cpu_next = cmd_bits[0];
            soft_per_next = cmd_bits[1];
          end
          else if (tick && pin_en && !pin_level && !ext_ignore_reg) // [RL20]
            state_next = ST_USER;
        end
      endcase
    end
    if (state_reg != ST_WDOG && state_next == ST_WDOG)
    begin
      wd_per_next = !watchdog_cpu_only; // [RL7] [RL8]
      if (!watchdog_cpu_only)
      begin
        ext_cnt_next = pulse_len(len_field); // [RL7] [RL19]
        ext_ignore_next = 1'b1;
      end
    end
    if (state_reg == ST_IDLE && state_next == ST_SOFT && cmd_bits[2])
    begin
      ext_cnt_next = pulse_len(len_field); // [RL2] [RL19]
      ext_ignore_next = 1'b1;
    end
  end

  // reset lines follow the next state so a command asserts them at once
  always_comb
  begin
    case (state_next)
      ST_BACKUP, ST_WAKE, ST_USER: lines_next = '{cpu_reset: 1'b1, periph_reset: 1'b1};
      ST_WDOG: lines_next = '{cpu_reset: 1'b1, periph_reset: wd_per_next}; // [RL7] [RL8]
      ST_SOFT: lines_next = '{cpu_reset: soft_cpu_next, periph_reset: soft_per_next}; // [RL1]
      default: lines_next = '{cpu_reset: 1'b0, periph_reset: 1'b0};
    endcase
  end

  wire pin_drive_next = ext_cnt_next != 17'h0 || state_next == ST_BACKUP
                        || state_next == ST_WAKE;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_reg <= ST_IDLE;
      cnt_reg <= 2'h0;
      busy_reg <= 1'b0;
      soft_cpu_reg <= 1'b0;
      soft_per_reg <= 1'b0;
      wd_per_reg <= 1'b0;
      ext_cnt_reg <= 17'h0;
      ext_ignore_reg <= 1'b0;
      lines_reg <= '0;
      pin_oe_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      busy_reg <= busy_next;
      soft_cpu_reg <= soft_cpu_next;
      soft_per_reg <= soft_per_next;
      wd_per_reg <= wd_per_next;
      ext_cnt_reg <= ext_cnt_next;
      ext_ignore_reg <= ext_ignore_next;
      lines_reg <= lines_next;
      pin_oe_reg <= pin_drive_next;
    end
  end

  // status, mode and interrupt registers; backup reset clears the retained state
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cause_reg <= STATUS_MAIN_RESET[ST_CAUSE_LSB +: 3]; // [RL21]
      edge_reg <= STATUS_MAIN_RESET[ST_EDGE_BIT];
      mode_reg <= MODE_RESET;
      irq_reg <= 1'b0;
    end
    else if (!backup_reset_n)
    begin
      cause_reg <= STATUS_BACKUP_RESET[ST_CAUSE_LSB +: 3]; // [RL21]
      edge_reg <= STATUS_BACKUP_RESET[ST_EDGE_BIT];
      mode_reg <= MODE_RESET;
      irq_reg <= 1'b0;
    end
    else
    begin
      cause_reg <= cause_next; // [RL16]
      edge_reg <= edge_next; // [RL14]
      if (wr_mode && key_ok) // [RL17]
        mode_reg <= w_data_reg & MODE_WRITE_MASK;
      irq_reg <= edge_next && !pin_en && irq_en; // [RL15]
    end
  end

  // the first stage is read only by the second
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pin_s1_reg <= 1'b1;
      pin_s2_reg <= 1'b1;
      pin_prev_reg <= 1'b1;
      slow_prev_reg <= 1'b0;
    end
    else
    begin
      pin_s1_reg <= pin_in; // [RL23]
      pin_s2_reg <= pin_s1_reg; // [RL23] [RL13]
      pin_prev_reg <= pin_s2_reg;
      slow_prev_reg <= slow_clock;
    end
  end

  // axi4-lite write side: address and data taken in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h0000_0000;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_full_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
      end
      if (wr_fire)
      begin
        aw_full_reg <= 1'b0;
        w_full_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bvalid_reg && s_axi_bready)
        bvalid_reg <= 1'b0;
    end
  end

  // axi4-lite read side; a status read clears the edge flag
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= RESP_OKAY;
    end
    else if (rd_fire)
    begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_status ? status_word : (rd_mode ? mode_reg : 32'h0000_0000);
      rresp_reg <= (rd_status || rd_mode) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (rvalid_reg && s_axi_rready)
      rvalid_reg <= 1'b0;
  end

  assign s_axi_awready = !aw_full_reg && !bvalid_reg;
  assign s_axi_wready = !w_full_reg && !bvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign rst_lines = lines_reg;
  assign pin_oe = pin_oe_reg;
  assign pin_out = 1'b0;
  assign irq = irq_reg;

endmodule // reset_controller_core

/* test/reset_far_side.sv */
// Purpose: far side model: slow clock, pulled-up reset pin, watchdog fault
// Assumes: slow clock runs free at one eighth of aclk
// Notes: pin is open drain; anyone may pull it low
`timescale 1ns/1ps
module reset_far_side
(
  // clock
  input wire logic aclk,
  // pin pulls and watchdog request
  input wire logic pin_oe,
  input wire logic ext_low,
  input wire logic kick,
  // far side outputs
  output logic slow_clock,
  output logic pin_in,
  output logic watchdog_fault
);
  logic [2:0] div_reg = 3'h0;
  // pull-up wins unless the device or the outside pulls low
  assign pin_in = !(pin_oe || ext_low);
  assign slow_clock = div_reg[2];
  always_ff @(posedge aclk)
  begin
    div_reg <= div_reg + 3'h1;
    watchdog_fault <= kick;
  end
endmodule // reset_far_side

/* test/reset_controller_asserts.sv */
// Purpose: port-level checks of the reset controller
// Assumes: sees only the top module ports
// Notes: quiet means no line, no pin drive, supplies up
`timescale 1ns/1ps
module reset_controller_asserts
  import reset_controller_pkg::*;
#(
  parameter int HOLD_CYCLES = HOLD_SLOW_CYCLES
)
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  // sources and outputs
  input wire logic backup_reset_n,
  input wire logic main_por_n,
  input wire logic watchdog_fault,
  input wire logic watchdog_reset_enable,
  input wire logic watchdog_cpu_only,
  input wire logic pin_in,
  input wire logic pin_oe,
  input wire rst_lines_t rst_lines,
  input wire logic irq
);
  wire quiet_w = rst_lines == 2'b00 && !pin_oe && backup_reset_n && main_por_n;
  wire cmd_w = quiet_w && !watchdog_fault && s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready && s_axi_awaddr == REG_COMMAND && s_axi_wdata[31:24] == WRITE_KEY;
  wire rd_st = s_axi_arvalid && s_axi_arready && s_axi_araddr == REG_STATUS;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // the write lands one edge after the handshake and the lines show one edge later
  a_cmd_cpu: assert property (cmd_w && s_axi_wdata[0] |-> ##2 rst_lines.cpu_reset)
    else $error("cpu reset not raised by command");
  a_cmd_periph: assert property (cmd_w && s_axi_wdata[2] |-> ##2 rst_lines.periph_reset)
    else $error("peripheral reset not raised by command");
  a_cmd_pin: assert property (cmd_w && s_axi_wdata[3] |-> ##2 pin_oe)
    else $error("pin not driven by command");
  // fault reaches the state machine at once; lines and pin show one edge later
  a_wdog_cpu_only: assert property (quiet_w && watchdog_fault && watchdog_reset_enable
    && watchdog_cpu_only && pin_in && !s_axi_awvalid
    |=> (!rst_lines.periph_reset && !pin_oe) [*6]) else $error("watchdog raised too much");
  a_wdog_full: assert property (quiet_w && watchdog_fault && watchdog_reset_enable
    && !watchdog_cpu_only |-> ##[1:3] (rst_lines == 2'b11 && pin_oe))
    else $error("watchdog lines missing");
  a_wdog_off: assert property (quiet_w && watchdog_fault && !watchdog_reset_enable
    && !s_axi_awvalid && pin_in && $past(pin_in) && $past(pin_in, 2) && $past(pin_in, 3)
    |=> rst_lines == 2'b00) else $error("disabled watchdog caused reset");
  a_level_bit: assert property (rd_st && pin_in == $past(pin_in)
    && pin_in == $past(pin_in, 2) && pin_in == $past(pin_in, 3)
    |=> s_axi_rdata[16] == $past(pin_in)) else $error("pin level bit wrong");
  a_cause_legal: assert property (rd_st |=> s_axi_rdata[10:8] <= CAUSE_USER)
    else $error("reset cause out of range");
  a_irq_clear: assert property (rd_st && pin_in && $past(pin_in) && $past(pin_in, 2)
    && $past(pin_in, 3) |-> ##2 !irq) else $error("irq not cleared by status read");
endmodule // reset_controller_asserts
bind reset_controller_core reset_controller_asserts #(.HOLD_CYCLES(HOLD_CYCLES))
  i_reset_controller_asserts (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .backup_reset_n, .main_por_n,
  .watchdog_fault, .watchdog_reset_enable, .watchdog_cpu_only, .pin_in, .pin_oe,
  .rst_lines, .irq);

/* test/reset_controller_core_test.sv */
// Purpose: self-checking bench for the reset controller
// Assumes: slow tick every DIV aclk cycles from the far side model
// Notes: spans allow one partial first slow tick
`timescale 1ns/1ps
module reset_controller_core_test
  import reset_controller_pkg::*;
;
  localparam int DIV = 8;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic backup_reset_n, watchdog_reset_enable, watchdog_cpu_only, ext_low, kick;
  logic slow_clock, pin_in, pin_out, pin_oe, watchdog_fault, irq;
  rst_lines_t rst_lines;
  int fail_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  int t0;
  initial
  begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  always @(posedge aclk) cyc <= cyc + 1;
  reset_controller_core i_reset_controller_core (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .slow_clock, .backup_reset_n, .main_por_n(1'b1), .watchdog_fault,
    .watchdog_reset_enable, .watchdog_cpu_only, .pin_in, .pin_out(), .pin_oe,
    .rst_lines, .irq);
  reset_far_side i_reset_far_side (.aclk, .pin_oe, .ext_low, .kick, .slow_clock, .pin_in,
    .watchdog_fault);
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  function automatic logic [31:0] lines3();
    return {29'h0, pin_oe, rst_lines.periph_reset, rst_lines.cpu_reset};
  endfunction
  // bus tasks hold every request until its own ready, answers until seen
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    n = 0;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1 && n < 50);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
    t0 = cyc;
  endtask
  task automatic rdr(input logic [7:0] a);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    n = 0;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1 && n < 50);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic wait_quiet();
    int n;
    n = 0;
    while ((rst_lines !== 2'b00 || pin_oe !== 1'b0) && n < 2000)
    begin
      @(posedge aclk);
      n++;
    end
  endtask
  task automatic fault();
    @(posedge aclk);
    kick <= 1'b1;
    @(posedge aclk);
    kick <= 1'b0;
  endtask
  task automatic t_regs();
    rdr(REG_STATUS);
    check("status", STATUS_MAIN_RESET | 32'h0001_0000, rd);
    rdr(REG_STATUS);
    check("status reread", 32'h0001_0000, rd);
    rdr(REG_MODE);
    check("mode", MODE_RESET, rd);
    rdr(8'h0C);
    check("unmapped resp", 32'(RESP_SLVERR), 32'(rs));
    wr(REG_MODE, 32'h5A00_0F11);
    rdr(REG_MODE);
    check("mode bad key", MODE_RESET, rd);
    wr(REG_MODE, 32'hA5FF_FFFF);
    rdr(REG_MODE);
    check("mode masked", MODE_WRITE_MASK, rd);
    backup_reset_n <= 1'b0;
    fault();
    repeat (3) @(posedge aclk);
    backup_reset_n <= 1'b1;
    wait_quiet();
    rdr(REG_STATUS);
    check("status backup", 32'h0001_0000, rd & 32'hFFFF_FFFE);
    rdr(REG_MODE);
    check("mode backup", MODE_RESET, rd);
  endtask
  task automatic t_soft();
    logic [3:0] cmds [4];
    logic [2:0] cause;
    cmds = '{4'h4, 4'h1, 4'h8, 4'hD};
    cause = CAUSE_GENERAL;
    wr(REG_MODE, 32'hA500_0001);
    for (int i = 0; i < 4; i++)
    begin
      wr(REG_COMMAND, {WRITE_KEY, 20'h0, cmds[i]});
      check("cmd lines", {29'h0, cmds[i][3], cmds[i][2], cmds[i][0]}, lines3());
      rdr(REG_STATUS);
      check("busy", 32'h1, 32'(rd[ST_BUSY_BIT]));
      wr(REG_COMMAND, {WRITE_KEY, 24'h5});
      check("busy cmd", {29'h0, 1'b0, cmds[i][2], cmds[i][0]}, lines3() & 32'h3);
      wait_quiet();
      check("soft span", 32'h1, 32'(cyc - t0 <= HOLD_SLOW_CYCLES * DIV + 1));
      repeat (3 * DIV) @(posedge aclk);
      check("no user", 32'h0, lines3());
      if (cmds[i][0]) cause = CAUSE_SOFTWARE;
      rdr(REG_STATUS);
      check("cause", {14'h0, 1'b0, 1'b1, 5'h0, cause, 8'h0}, rd & 32'h0003_0700);
    end
    wr(REG_COMMAND, 32'h5A00_0001);
    check("cmd bad key", 32'h0, lines3());
    wr(REG_MODE, 32'hA500_0200);
    wr(REG_COMMAND, {WRITE_KEY, 24'h8});
    wait_quiet();
    check("pin length", 32'h1, 32'(cyc - t0 >= 7 * DIV - 1 && cyc - t0 <= 8 * DIV + 1));
  endtask
  task automatic t_wdog();
    wr(REG_MODE, 32'hA500_0001);
    watchdog_reset_enable <= 1'b1;
    watchdog_cpu_only <= 1'b1;
    fault();
    repeat (4) @(posedge aclk);
    check("wdog cpu only", 32'h1, lines3());
    wr(REG_COMMAND, {WRITE_KEY, 24'h4});
    check("cmd in wdog", 32'h1, lines3());
    wait_quiet();
    rdr(REG_STATUS);
    check("wdog cause", 32'h0001_0200, rd & 32'h0003_0700);
    watchdog_cpu_only <= 1'b0;
    wr(REG_COMMAND, {WRITE_KEY, 24'h1});
    fault();
    repeat (4) @(posedge aclk);
    check("wdog full", 32'h7, lines3());
    wait_quiet();
    repeat (3 * DIV) @(posedge aclk);
    check("wdog no user", 32'h0, lines3());
    rdr(REG_STATUS);
    check("takeover cause", 32'h0001_0200, rd & 32'h0003_0700);
    watchdog_reset_enable <= 1'b0;
    fault();
    repeat (4) @(posedge aclk);
    check("wdog off", 32'h0, lines3());
  endtask
  task automatic t_user();
    ext_low <= 1'b1;
    repeat (3 * DIV) @(posedge aclk);
    check("user lines", 32'h3, lines3());
    wr(REG_COMMAND, {WRITE_KEY, 24'h8});
    check("cmd in user", 32'h3, lines3());
    rdr(REG_STATUS);
    check("low level edge", 32'h1, rd & 32'h0001_0001);
    ext_low <= 1'b0;
    wait_quiet();
    rdr(REG_STATUS);
    check("user cause", 32'h0001_0400, rd & 32'h0003_0700);
    wr(REG_MODE, 32'hA500_0010);
    ext_low <= 1'b1;
    repeat (2 * DIV) @(posedge aclk);
    check("pin off", 32'h0, lines3());
    ext_low <= 1'b0;
    repeat (2) @(posedge aclk);
    check("irq set", 32'h1, 32'(irq));
    rdr(REG_STATUS);
    repeat (3) @(posedge aclk);
    check("irq clear", 32'h0, 32'(irq));
  endtask
  initial
  begin
    aresetn = 1'b0;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0000_0000;
    backup_reset_n = 1'b1;
    watchdog_reset_enable = 1'b0;
    watchdog_cpu_only = 1'b0;
    ext_low = 1'b0;
    kick = 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_soft();
    t_wdog();
    t_user();
    close_out();
  end
  // generous against the several hundred cycles the tests take
  initial
  begin
    #100000;
    fail_count++;
    close_out();
  end
endmodule // reset_controller_core_test
